// [vcp_pkg.sv]
// constants for the colour-index path and palette access port
package vcp_pkg;
    // host port addresses (io space, and the memory-space alias of the data port)
    localparam logic [15:0] ADDR_MASK     = 16'h03C6;
    localparam logic [15:0] ADDR_RD_PTR   = 16'h03C7;
    localparam logic [15:0] ADDR_WR_PTR   = 16'h03C8;
    localparam logic [15:0] ADDR_DATA_IO  = 16'h03C9;
    localparam logic [15:0] ADDR_DATA_MEM = 16'h03C1;
    // attribute register indices
    localparam logic [4:0]  IDX_MODE      = 5'h10;
    localparam logic [4:0]  IDX_PLANE     = 5'h12;
    localparam logic [4:0]  IDX_PAN       = 5'h13;
    localparam logic [4:0]  IDX_SEL       = 5'h14;
    // field positions
    localparam int          MODE_P54_BIT  = 7;
    localparam int          MODE_PW_BIT   = 6;
    // palette access state codes
    localparam logic [1:0]  STATE_WR_LAST = 2'h0;
    localparam logic [1:0]  STATE_RD_LAST = 2'h3;
    // status mux selector codes
    localparam logic [1:0]  MUX_P2_P0     = 2'h0;
    localparam logic [1:0]  MUX_P5_P4     = 2'h1;
    localparam logic [1:0]  MUX_P3_P1     = 2'h2;
    localparam logic [1:0]  MUX_P7_P6     = 2'h3;
    // reset values, and the shift given for undefined pan cells
    localparam logic [7:0]  MASK_RST      = 8'hFF;
    localparam logic [7:0]  ATTR_RST      = 8'h00;
    localparam logic [7:0]  PTR_RST       = 8'h00;
    localparam logic [3:0]  PAN_UNDEF     = 4'h0;
    // red/green/blue byte sequencer
    typedef enum logic [1:0] {BYTE_RED, BYTE_GREEN, BYTE_BLUE} vcp_byte_e;
endpackage

// [vcp_palette_port.sv]
// colour-index path, pixel panning and palette access port
`timescale 1ns/1ps
// Overview of operation
// R01: status mux field picks P2/P0, P5/P4, P3/P1 or P7/P6 for status read-back.
// R02: each plane-enable bit low forces that plane's index bit to zero.
// R03: 9-dot text pans left by value plus one for 0..7, zero for 8.
// R04: pseudo 9-dot like 9-dot but 7 gives 7; 8-dot pans by value.
// R05: 256-colour mode pans by half the value; software keeps bit 0 clear.
// R06: colour-select bits 3:2 supply P7 and P6 for all attribute entries.
// R07: with the P5/P4 select set, colour-select bits 1:0 supply P5 and P4.
// R08: one palette per display pipe; host port targets a selectable pipe.
// R09: 256 three-byte colours via data port plus read and write pointers.
// R10: three data reads return red, green, blue, then read pointer increments.
// R11: entry committed only after third written byte, then write pointer increments.
// R12: 768 consecutive data accesses from zero cover the whole palette.
// R13: pixel mask ANDed with pixel value forms the palette lookup index.
// R14: access state reads 00 after write-pointer write, 11 after read-pointer write.
// R15: writing the read pointer aborts a partial three-byte palette write.
// R16: palette port works in every display mode, VGA or not.
// R17: data port at 3C9h (memory 3C1h), read pointer 3C7h, write pointer 3C8h.
// R18: writing either pointer restarts the byte sequencer at red.
// R19: write colliding with display read of same entry repeats previous pixel.
// R20: pixel-width mode pairs two nibbles into one index every other dot.
// R21: selected status bits are offered for input status bits 5 and 4.
// R22: pointers wrap from 255 to 0 on auto-increment.
// R23: planes, attribute map, mask, then palette lookup give 24-bit colour.
module vcp_palette_port #(
    parameter int NUM_PIPES = 2,
    parameter int PIPE_W    = (NUM_PIPES > 1) ? $clog2(NUM_PIPES) : 1
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [15:0]       io_addr_i,
    input  wire logic              io_mem_space_i,
    input  wire logic              io_wr_i,
    input  wire logic              io_rd_i,
    input  wire logic [7:0]        io_wdata_i,
    output logic      [7:0]        io_rdata_o,
    input  wire logic [PIPE_W-1:0] host_pipe_i,
    input  wire logic [PIPE_W-1:0] disp_pipe_i,
    input  wire logic              attr_wr_i,
    input  wire logic [4:0]        attr_index_i,
    input  wire logic [7:0]        attr_wdata_i,
    output logic      [7:0]        attr_rdata_o,
    input  wire logic              pix_valid_i,
    input  wire logic [3:0]        plane_bits_i,
    input  wire logic              char9_i,
    input  wire logic              pseudo9_i,
    output logic      [23:0]       rgb_o,
    output logic                   rgb_valid_o,
    output logic      [1:0]        status_bits_o,
    output logic      [3:0]        pan_shift_o
);
    localparam int DEPTH = NUM_PIPES * 256;

    // palette storage, one 256-entry bank per pipe, entry = {red, green, blue}
    logic [23:0]              pal_mem [DEPTH];
    logic [7:0]               attr_ent_ff [16];
    logic [7:0]               mode_ff;
    logic [7:0]               plane_ff;
    logic [7:0]               pan_ff;
    logic [7:0]               sel_ff;
    logic [7:0]               mask_ff;
    logic [7:0]               rd_ptr_ff;
    logic [7:0]               wr_ptr_ff;
    logic [1:0]               state_ff;
    vcp_pkg::vcp_byte_e       seq_ff;
    logic [7:0]               red_ff;
    logic [7:0]               green_ff;
    logic                     half_ff;
    logic [3:0]               nib_ff;
    logic [7:0]               idx_ff;
    logic                     idx_v_ff;
    logic [7:0]               look_ff;
    logic                     look_v_ff;
    logic [PIPE_W-1:0]        look_pipe_ff;

    // address decode: the data port moves to its alias in memory space
    function automatic logic is_data(input logic [15:0] a, input logic mem);
        is_data = (a == (mem ? vcp_pkg::ADDR_DATA_MEM : vcp_pkg::ADDR_DATA_IO));
    endfunction

    function automatic logic [8+PIPE_W-1:0] mem_addr(input logic [PIPE_W-1:0] p, input logic [7:0] i);
        mem_addr = {p, i};
    endfunction

    logic wr_rd_ptr;
    logic wr_wr_ptr;
    logic wr_data;
    logic rd_data;
    logic pal_we;
    assign wr_rd_ptr = io_wr_i && (io_addr_i == vcp_pkg::ADDR_RD_PTR);  // [R17]
    assign wr_wr_ptr = io_wr_i && (io_addr_i == vcp_pkg::ADDR_WR_PTR);  // [R17]
    assign wr_data   = io_wr_i && is_data(io_addr_i, io_mem_space_i);   // [R17]
    assign rd_data   = io_rd_i && is_data(io_addr_i, io_mem_space_i);
    // commit only on the blue byte; a read-pointer write in the same cycle wins
    assign pal_we    = wr_data && (seq_ff == vcp_pkg::BYTE_BLUE) && !wr_rd_ptr && !wr_wr_ptr; // [R11] [R15]

    // byte sequencer shared by reads and writes, restarted by any pointer write
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || wr_rd_ptr || wr_wr_ptr)
        begin
            seq_ff <= vcp_pkg::BYTE_RED;  // [R18] [R15]
        end
        else if (wr_data || rd_data)
        begin
            case (seq_ff)
                vcp_pkg::BYTE_RED:   seq_ff <= vcp_pkg::BYTE_GREEN;
                vcp_pkg::BYTE_GREEN: seq_ff <= vcp_pkg::BYTE_BLUE;
                vcp_pkg::BYTE_BLUE:  seq_ff <= vcp_pkg::BYTE_RED;
                default:             seq_ff <= vcp_pkg::BYTE_RED;
            endcase
        end
    end

    // pointers; 8-bit adds wrap 255 to 0 on their own
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rd_ptr_ff <= vcp_pkg::PTR_RST;
            wr_ptr_ff <= vcp_pkg::PTR_RST;
        end
        else
        begin
            if (wr_rd_ptr)
                rd_ptr_ff <= io_wdata_i;
            else if (rd_data && seq_ff == vcp_pkg::BYTE_BLUE)
                rd_ptr_ff <= rd_ptr_ff + 8'h01;  // [R10] [R22] [R12]
            if (wr_wr_ptr)
                wr_ptr_ff <= io_wdata_i;
            else if (pal_we)
                wr_ptr_ff <= wr_ptr_ff + 8'h01;  // [R11] [R22] [R12]
        end
    end

    // access state remembers which pointer was written last
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            state_ff <= vcp_pkg::STATE_WR_LAST;
        else if (wr_rd_ptr)
            state_ff <= vcp_pkg::STATE_RD_LAST;  // [R14]
        else if (wr_wr_ptr)
            state_ff <= vcp_pkg::STATE_WR_LAST;  // [R14]
    end

    // red and green wait here so a half-written colour never reaches the array
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            red_ff   <= 8'h00;
            green_ff <= 8'h00;
        end
        else if (wr_data && seq_ff == vcp_pkg::BYTE_RED)
            red_ff   <= io_wdata_i;
        else if (wr_data && seq_ff == vcp_pkg::BYTE_GREEN)
            green_ff <= io_wdata_i;
    end

    // palette write port, open in every display mode
    always_ff @(posedge clk_i)
    begin
        if (pal_we)
            pal_mem[mem_addr(host_pipe_i, wr_ptr_ff)] <= {red_ff, green_ff, io_wdata_i};  // [R08] [R09] [R16]
    end

    // host read data, one cycle after the strobe
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            io_rdata_o <= 8'h00;
        else if (rd_data)
        begin
            case (seq_ff)  // [R10]
                vcp_pkg::BYTE_RED:   io_rdata_o <= pal_mem[mem_addr(host_pipe_i, rd_ptr_ff)][23:16];
                vcp_pkg::BYTE_GREEN: io_rdata_o <= pal_mem[mem_addr(host_pipe_i, rd_ptr_ff)][15:8];
                default:             io_rdata_o <= pal_mem[mem_addr(host_pipe_i, rd_ptr_ff)][7:0];
            endcase
        end
        else if (io_rd_i && io_addr_i == vcp_pkg::ADDR_MASK)
            io_rdata_o <= mask_ff;
        else if (io_rd_i && io_addr_i == vcp_pkg::ADDR_RD_PTR)
            io_rdata_o <= {6'h00, state_ff};  // [R14]
        else if (io_rd_i)
            io_rdata_o <= 8'h00;
    end

    // pixel mask register
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            mask_ff <= vcp_pkg::MASK_RST;
        else if (io_wr_i && io_addr_i == vcp_pkg::ADDR_MASK)
            mask_ff <= io_wdata_i;
    end

    // attribute registers, written once the outer index logic has picked one
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mode_ff  <= vcp_pkg::ATTR_RST;
            plane_ff <= vcp_pkg::ATTR_RST;
            pan_ff   <= vcp_pkg::ATTR_RST;
            sel_ff   <= vcp_pkg::ATTR_RST;
            for (int i = 0; i < 16; i++)
                attr_ent_ff[i] <= vcp_pkg::ATTR_RST;
        end
        else if (attr_wr_i)
        begin
            case (attr_index_i)
                vcp_pkg::IDX_MODE:  mode_ff  <= attr_wdata_i;
                vcp_pkg::IDX_PLANE: plane_ff <= {2'h0, attr_wdata_i[5:0]};
                vcp_pkg::IDX_PAN:   pan_ff   <= {4'h0, attr_wdata_i[3:0]};
                vcp_pkg::IDX_SEL:   sel_ff   <= {4'h0, attr_wdata_i[3:0]};
                default:
                begin
                    if (!attr_index_i[4])
                        attr_ent_ff[attr_index_i[3:0]] <= {2'h0, attr_wdata_i[5:0]};
                end
            endcase
        end
    end

    // attribute read-back, reserved bits read as zero
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            attr_rdata_o <= 8'h00;
        else
        begin
            case (attr_index_i)
                vcp_pkg::IDX_MODE:  attr_rdata_o <= mode_ff & 8'hEF;
                vcp_pkg::IDX_PLANE: attr_rdata_o <= plane_ff;
                vcp_pkg::IDX_PAN:   attr_rdata_o <= pan_ff;
                vcp_pkg::IDX_SEL:   attr_rdata_o <= sel_ff;
                default:            attr_rdata_o <= attr_index_i[4] ? 8'h00 : attr_ent_ff[attr_index_i[3:0]];
            endcase
        end
    end

    // stage 1: plane enable and attribute mapping, or nibble pairing
    logic [3:0] pe_bits;
    logic [7:0] ent;
    assign pe_bits = plane_bits_i & plane_ff[3:0];  // [R02]
    assign ent     = attr_ent_ff[pe_bits];
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            half_ff  <= 1'b0;
            nib_ff   <= 4'h0;
            idx_ff   <= 8'h00;
            idx_v_ff <= 1'b0;
        end
        else if (pix_valid_i && mode_ff[vcp_pkg::MODE_PW_BIT])
        begin
            // first nibble is held, the second completes the index; entries bypassed
            half_ff  <= !half_ff;  // [R20]
            nib_ff   <= pe_bits;
            idx_ff   <= {nib_ff, pe_bits};
            idx_v_ff <= half_ff;  // [R20]
        end
        else
        begin
            half_ff  <= 1'b0;
            idx_ff   <= {sel_ff[3:2],  // [R06] [R23]
                         mode_ff[vcp_pkg::MODE_P54_BIT] ? sel_ff[1:0] : ent[5:4],  // [R07]
                         ent[3:0]};
            idx_v_ff <= pix_valid_i;
        end
    end

    // stage 2: pixel mask and status mux
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            look_ff       <= 8'h00;
            look_v_ff     <= 1'b0;
            look_pipe_ff  <= '0;
            status_bits_o <= 2'h0;
        end
        else
        begin
            look_ff      <= idx_ff & mask_ff;  // [R13]
            look_v_ff    <= idx_v_ff;
            look_pipe_ff <= disp_pipe_i;
            case (plane_ff[5:4])  // [R01] [R21]
                vcp_pkg::MUX_P2_P0: status_bits_o <= {idx_ff[2], idx_ff[0]};
                vcp_pkg::MUX_P5_P4: status_bits_o <= {idx_ff[5], idx_ff[4]};
                vcp_pkg::MUX_P3_P1: status_bits_o <= {idx_ff[3], idx_ff[1]};
                default:            status_bits_o <= {idx_ff[7], idx_ff[6]};
            endcase
        end
    end

    // stage 3: lookup; a same-entry write repeats the last pixel to stop sparkle
    logic collide;
    assign collide = pal_we && (mem_addr(host_pipe_i, wr_ptr_ff) == mem_addr(look_pipe_ff, look_ff));
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rgb_o       <= 24'h000000;
            rgb_valid_o <= 1'b0;
        end
        else
        begin
            rgb_valid_o <= look_v_ff;
            if (look_v_ff && !collide)
                rgb_o <= pal_mem[mem_addr(look_pipe_ff, look_ff)];  // [R23] [R08]
            // on collision rgb_o simply holds  [R19]
        end
    end

    // pan amount; undefined table cells give no shift
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            pan_shift_o <= 4'h0;
        else if (mode_ff[vcp_pkg::MODE_PW_BIT])
            pan_shift_o <= pan_ff[0] ? vcp_pkg::PAN_UNDEF : {1'b0, pan_ff[3:1]};  // [R05]
        else if (char9_i)
        begin
            if (pan_ff[3:0] > 4'h8)
                pan_shift_o <= vcp_pkg::PAN_UNDEF;
            else if (pan_ff[3:0] == 4'h8)
                pan_shift_o <= 4'h0;  // [R03]
            else if (pseudo9_i && pan_ff[3:0] == 4'h7)
                pan_shift_o <= 4'h7;  // [R04]
            else
                pan_shift_o <= pan_ff[3:0] + 4'h1;  // [R03]
        end
        else
            pan_shift_o <= pan_ff[3] ? vcp_pkg::PAN_UNDEF : pan_ff[3:0];  // [R04]
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    seq_restart_a: assert property ((wr_rd_ptr || wr_wr_ptr) |=> seq_ff == vcp_pkg::BYTE_RED) // [R18]
        else $error("sequencer not restarted by pointer write");
    state_rd_a: assert property (wr_rd_ptr |=> state_ff == vcp_pkg::STATE_RD_LAST) // [R14]
        else $error("state not 11 after read pointer write");
    state_wr_a: assert property (wr_wr_ptr && !wr_rd_ptr |=> state_ff == vcp_pkg::STATE_WR_LAST) // [R14]
        else $error("state not 00 after write pointer write");
    wr_commit_a: assert property (pal_we |=> wr_ptr_ff == $past(wr_ptr_ff) + 8'h01) // [R11]
        else $error("write pointer did not advance after commit");
    rd_step_a: assert property (rd_data && !wr_rd_ptr && seq_ff == vcp_pkg::BYTE_BLUE
                                |=> rd_ptr_ff == $past(rd_ptr_ff) + 8'h01) // [R10]
        else $error("read pointer did not advance after blue");
    abort_write_a: assert property (wr_rd_ptr |-> !pal_we ##1 seq_ff == vcp_pkg::BYTE_RED) // [R15]
        else $error("partial write committed after read pointer write");
    pixel_mask_a: assert property (##1 look_ff == ($past(idx_ff) & $past(mask_ff))) // [R13]
        else $error("lookup index not masked");
    pan_nine_a: assert property (!mode_ff[vcp_pkg::MODE_PW_BIT] && char9_i && pan_ff[3:0] == 4'h8
                                 |=> pan_shift_o == 4'h0) // [R03]
        else $error("9-dot pan of 8 not zero");
    sparkle_hold_a: assert property (collide && look_v_ff |=> $stable(rgb_o)) // [R19]
        else $error("pixel changed on colliding write");

    full_write_c: cover property (wr_data && seq_ff == vcp_pkg::BYTE_RED ##1 wr_data [*2]);
    full_read_c: cover property (rd_data [*3]);
    sparkle_c: cover property (collide && look_v_ff);
    nibble_pair_c: cover property (mode_ff[vcp_pkg::MODE_PW_BIT] && idx_v_ff);
endmodule

// [vcp_host_model.sv]
// host processor model issuing legacy palette port accesses
`timescale 1ns/1ps
module vcp_host_model (
    input  wire logic        clk_i,
    output logic      [15:0] io_addr_o,
    output logic             io_mem_space_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [7:0]  io_wdata_o,
    output logic      [0:0]  host_pipe_o
);
    // idle bus at time zero, strobes low
    initial
    begin
        io_addr_o = 16'h0000;
        io_mem_space_o = 1'b0;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
        host_pipe_o = 1'b0;
    end
    // one access per call, held for a whole cycle so back-to-back calls need no gap
    task automatic access(input logic wr, input logic rd, input logic [15:0] a, input logic [7:0] d, input logic mem);
        @(negedge clk_i);
        io_wr_o = wr;
        io_rd_o = rd;
        io_addr_o = a;
        io_wdata_o = d;
        io_mem_space_o = mem;
    endtask
    // released lines show the inverse so a stale value can never pass for a fresh one
    task automatic idle();
        @(negedge clk_i);
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_addr_o = ~io_addr_o;
        io_wdata_o = ~io_wdata_o;
    endtask
    // strobes drop with the pipe change, else a held read would be taken again
    task automatic pipe(input logic [0:0] p);
        @(negedge clk_i);
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        host_pipe_o = p;
    endtask
    // a colour always goes out whole: red, green, blue
    task automatic colour_wr(input logic [23:0] c);
        access(1'b1, 1'b0, vcp_pkg::ADDR_DATA_IO, c[23:16], 1'b0);
        access(1'b1, 1'b0, vcp_pkg::ADDR_DATA_IO, c[15:8], 1'b0);
        access(1'b1, 1'b0, vcp_pkg::ADDR_DATA_IO, c[7:0], 1'b0);
    endtask
endmodule

// [vcp_palette_port_test.sv]
// self-checking testbench for the colour-index path and palette port
`timescale 1ns/1ps
module vcp_palette_port_test;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [15:0] io_addr;
    logic        io_mem, io_wr, io_rd, attr_wr, pix_valid, char9, pseudo9, rgb_valid, rd_seen;
    logic [7:0]  io_wdata, io_rdata, attr_wdata, attr_rdata, mode, plane, sel, mask;
    logic [0:0]  host_pipe, disp_pipe;
    logic [4:0]  attr_index;
    logic [3:0]  plane_bits, pan_shift;
    logic [1:0]  status_bits;
    logic [23:0] rgb;
    logic [23:0] pal [256];
    logic [5:0]  ent [16];
    logic [7:0]  q_byte [$];
    logic [23:0] q_rgb [$];
    logic [3:0]  q_stat [$];
    int          error_cnt, compares;
    int          seed = 32'h321f8b8d;

    vcp_palette_port u_vcp_palette_port (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr),
        .io_mem_space_i(io_mem), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
        .io_rdata_o(io_rdata), .host_pipe_i(host_pipe), .disp_pipe_i(disp_pipe), .attr_wr_i(attr_wr),
        .attr_index_i(attr_index), .attr_wdata_i(attr_wdata), .attr_rdata_o(attr_rdata),
        .pix_valid_i(pix_valid), .plane_bits_i(plane_bits), .char9_i(char9), .pseudo9_i(pseudo9),
        .rgb_o(rgb), .rgb_valid_o(rgb_valid), .status_bits_o(status_bits), .pan_shift_o(pan_shift));
    vcp_host_model u_vcp_host_model (.clk_i(clk_i), .io_addr_o(io_addr), .io_mem_space_o(io_mem),
        .io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata), .host_pipe_o(host_pipe));

    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    // mismatches print at once and are counted
    task automatic miss(input logic [23:0] e, input logic [23:0] g);
        $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
        error_cnt++;
    endtask
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) miss({16'h0000, e}, {16'h0000, g});
    endtask
    task automatic chk_rgb(input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) miss(e, g);
    endtask
    task automatic chk_small(input logic [3:0] e, input logic [3:0] g);
        compares++;
        if (g !== e) miss({20'h00000, e}, {20'h00000, g});
    endtask
    task automatic final_report();
        $display("counts: compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // read data lands one cycle after the read edge; pixels come with their valid pulse
    always @(posedge clk_i) rd_seen <= io_rd && rst_b_i;
    always @(negedge clk_i)
    begin
        if (rd_seen) chk_byte(q_byte.pop_front(), io_rdata);
        if (rgb_valid === 1'b1)
        begin
            chk_rgb(q_rgb.pop_front(), rgb);
            chk_small(q_stat.pop_front(), {2'h0, status_bits});
        end
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_vcp_host_model.access(1'b1, 1'b0, a, d, 1'b0);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic mem = 1'b0);
        q_byte.push_back(e);
        u_vcp_host_model.access(1'b0, 1'b1, a, 8'h00, mem);
    endtask
    // three data reads, red first; the mem flag sends them through the memory-space alias
    task automatic rd_colour(input logic [23:0] c, input logic mem);
        logic [15:0] a;
        a = mem ? vcp_pkg::ADDR_DATA_MEM : vcp_pkg::ADDR_DATA_IO;
        rd(a, c[23:16], mem);
        rd(a, c[15:8], mem);
        rd(a, c[7:0], mem);
    endtask
    // attribute writes are mirrored locally to work out expected pixels
    task automatic attr_set(input logic [4:0] i, input logic [7:0] d);
        @(negedge clk_i);
        attr_wr = 1'b1;
        attr_index = i;
        attr_wdata = d;
        @(negedge clk_i);
        attr_wr = 1'b0;
        case (i)
            vcp_pkg::IDX_MODE: mode = d;
            vcp_pkg::IDX_PLANE: plane = d;
            vcp_pkg::IDX_SEL: sel = d;
            default: if (i < 5'h10) ent[i[3:0]] = d[5:0];
        endcase
    endtask
    // one pixel, spaced out so the status bits still stand when the colour appears
    task automatic pix(input logic [3:0] pb);
        logic [5:0] e;
        logic [7:0] x;
        logic [1:0] m;
        e = ent[pb & plane[3:0]];
        x = {sel[3:2], mode[7] ? sel[1:0] : e[5:4], e[3:0]};
        m = plane[5:4];
        q_stat.push_back({2'h0, m == 2'h0 ? {x[2], x[0]} : m == 2'h1 ? {x[5], x[4]} : m == 2'h2 ? {x[3], x[1]} : {x[7], x[6]}});
        q_rgb.push_back(pal[x & mask]);
        u_vcp_host_model.idle();
        @(negedge clk_i);
        pix_valid = 1'b1;
        plane_bits = pb;
        @(negedge clk_i);
        pix_valid = 1'b0;  // plane bits stay: status bits track the index stage every cycle
        repeat (4) @(negedge clk_i);
    endtask
    // pan per mode: 0 nine-dot, 1 pseudo nine-dot, 2 eight-dot, 3 256-colour
    function automatic logic [3:0] pan_exp(input int m, input logic [3:0] v);
        if (m == 3) return v[0] ? 4'h0 : {1'b0, v[3:1]};
        if (m == 2) return (v < 4'h8) ? v : 4'h0;
        if (m == 1 && v == 4'h7) return 4'h7;
        return (v < 4'h8) ? v + 4'h1 : 4'h0;
    endfunction

    initial
    begin
        {attr_wr, pix_valid, char9, pseudo9, disp_pipe} = '0;
        {attr_index, attr_wdata, plane_bits} = '0;
        {mode, plane, sel} = '0;
        mask = vcp_pkg::MASK_RST;
        foreach (ent[i]) ent[i] = 6'h00;
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        rd(vcp_pkg::ADDR_RD_PTR, vcp_pkg::STATE_WR_LAST);
        rd(vcp_pkg::ADDR_MASK, vcp_pkg::MASK_RST);
        rd(vcp_pkg::ADDR_WR_PTR, 8'h00);
        rd(16'h03C5, 8'h00);
        $display("test reset_values done");
        wr(vcp_pkg::ADDR_WR_PTR, 8'h00);
        foreach (pal[j])
        begin
            pal[j] = 24'($random(seed));
            u_vcp_host_model.colour_wr(pal[j]);
        end
        wr(vcp_pkg::ADDR_RD_PTR, 8'h00);
        rd(vcp_pkg::ADDR_RD_PTR, vcp_pkg::STATE_RD_LAST);
        for (int j = 0; j < 256; j++) rd_colour(pal[j], j[0]);
        $display("test palette_fill done");
        wr(vcp_pkg::ADDR_WR_PTR, 8'hFF);
        pal[255] = 24'($random(seed));
        pal[0] = 24'($random(seed));
        u_vcp_host_model.colour_wr(pal[255]);
        u_vcp_host_model.colour_wr(pal[0]);
        rd(vcp_pkg::ADDR_RD_PTR, vcp_pkg::STATE_WR_LAST);
        wr(vcp_pkg::ADDR_RD_PTR, 8'hFF);
        rd_colour(pal[255], 1'b0);
        rd_colour(pal[0], 1'b0);
        $display("test pointer_wrap done");
        wr(vcp_pkg::ADDR_WR_PTR, 8'h05);
        wr(vcp_pkg::ADDR_DATA_IO, ~pal[5][23:16]);
        wr(vcp_pkg::ADDR_DATA_IO, ~pal[5][15:8]);
        wr(vcp_pkg::ADDR_RD_PTR, 8'h05);
        rd(vcp_pkg::ADDR_DATA_IO, pal[5][23:16]);
        wr(vcp_pkg::ADDR_RD_PTR, 8'h05);
        rd_colour(pal[5], 1'b0);
        $display("test abort_sequence done");
        u_vcp_host_model.pipe(1'b1);
        wr(vcp_pkg::ADDR_WR_PTR, 8'h09);
        u_vcp_host_model.colour_wr(~pal[9]);
        wr(vcp_pkg::ADDR_RD_PTR, 8'h09);
        rd_colour(~pal[9], 1'b0);
        u_vcp_host_model.pipe(1'b0);
        wr(vcp_pkg::ADDR_RD_PTR, 8'h09);
        rd_colour(pal[9], 1'b0);
        u_vcp_host_model.idle();
        $display("test pipe_select done");
        for (int i = 0; i < 16; i++) attr_set(i[4:0], 8'($random(seed)) & 8'h3F);
        for (int k = 0; k < 16; k++)
        begin
            attr_set(vcp_pkg::IDX_PLANE, {2'h0, k[1:0], 4'($random(seed))});
            attr_set(vcp_pkg::IDX_SEL, {4'h0, 4'($random(seed))});
            attr_set(vcp_pkg::IDX_MODE, {k[2], 7'h00});
            mask = (k < 8) ? 8'hFF : 8'($random(seed));
            wr(vcp_pkg::ADDR_MASK, mask);
            rd(vcp_pkg::ADDR_MASK, mask);
            pix(4'($random(seed)));
        end
        attr_set(vcp_pkg::IDX_PLANE, 8'hFF);
        @(negedge clk_i);
        chk_byte(8'h3F, attr_rdata);
        $display("test pixel_path done");
        for (int m = 0; m < 4; m++)
        begin
            @(negedge clk_i);
            char9 = (m < 2);
            pseudo9 = (m == 1);
            attr_set(vcp_pkg::IDX_MODE, {1'b0, m == 3, 6'h00});
            for (int v = 0; v < 9; v++)
            begin
                if (m == 3 && v % 2 == 1) continue; // software keeps pan bit 0 clear
                attr_set(vcp_pkg::IDX_PAN, v[7:0]);
                repeat (2) @(negedge clk_i);
                chk_small(pan_exp(m, v[3:0]), pan_shift);
            end
        end
        $display("test pixel_panning done");
        wr(vcp_pkg::ADDR_WR_PTR, 8'h03);
        u_vcp_host_model.colour_wr(~pal[3]);
        wr(vcp_pkg::ADDR_RD_PTR, 8'h03);
        rd_colour(~pal[3], 1'b1);
        u_vcp_host_model.idle();
        repeat (4) @(negedge clk_i);
        error_cnt += q_byte.size() + q_rgb.size();
        $display("test wide_mode_access done");
        final_report();
    end
    // the whole run needs well under 8000 cycles
    initial
    begin
        #1000000;
        error_cnt++;
        final_report();
    end
endmodule
